//--- core_status_and_bank_layout_bench.sv
// core_status_and_bank_layout_bench: table and directed tests of csbl_top
// assumes: csbl_top with a behavioural peripheral register responder
`timescale 1ns/1ps
`default_nettype none
module core_status_and_bank_layout_bench;
  import csbl_pkg::*;
  // ------------------------------------------------------------
  // stimulus, design and partner
  // ------------------------------------------------------------
  logic        clk = 1'b0, rst_b = 1'b0, por = 1'b1;
  logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr;
  logic        av = 1'b0, ads = 1'b0, adone, prd, pwx;
  logic        clrw = 1'b0, slp = 1'b0, wexp = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0]  pstrb = 4'h0;
  logic [7:0]  aa = 8'h00, ab = 8'h00, ares, flags, pwd, prdi, r;
  logic [11:0] padr;
  logic        e;
  csbl_op_t    aop = OP_ADD;
  int          bad_count = 0;
  int          cmp_count = 0;
  typedef struct {csbl_op_t op; logic [7:0] a, b, x; logic [2:0] f;} csbl_row_t;
  // each row: operation, operands, result and z/dc/c that should follow
  csbl_row_t rows [13] = '{
    '{OP_ADD, 8'h0f, 8'h01, 8'h10, 3'h2}, '{OP_ADD, 8'hf0, 8'h10, 8'h00, 3'h5},
    '{OP_SUB, 8'h05, 8'h05, 8'h00, 3'h7}, '{OP_SUB, 8'h10, 8'h01, 8'h0f, 3'h1},
    '{OP_SUB, 8'h00, 8'h01, 8'hff, 3'h0}, '{OP_AND, 8'hf0, 8'h0f, 8'h00, 3'h4},
    '{OP_IOR, 8'h81, 8'h00, 8'h81, 3'h0}, '{OP_XOR, 8'h5a, 8'h5a, 8'h00, 3'h4},
    '{OP_ADD, 8'h80, 8'h80, 8'h00, 3'h5}, '{OP_ROTR, 8'h02, 8'h00, 8'h81, 3'h4},
    '{OP_ROTL, 8'h81, 8'h00, 8'h02, 3'h5}, '{OP_CLR, 8'h33, 8'h00, 8'h00, 3'h5},
    '{OP_ROTL, 8'h00, 8'h00, 8'h01, 3'h4}};
  csbl_top u_csbl_top (
    .sys_clk_i(clk), .rst_b_i(rst_b), .cold_rst_i(por), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .alu_valid_i(av), .alu_op_i(aop),
    .alu_opa_i(aa), .alu_opb_i(ab), .alu_dest_status_i(ads),
    .alu_result_o(ares), .alu_done_o(adone),
    .watchdog_clear_instr_i(clrw), .sleep_instr_i(slp),
    .watchdog_timer_expired_i(wexp), .arith_reset_flags_o(flags),
    .periph_rd_o(prd), .periph_wr_o(pwx), .periph_addr_o(padr),
    .periph_wdata_o(pwd), .periph_rdata_i(prdi));
  csbl_periph_model u_csbl_periph_model (.sys_clk_i(clk), .rd_i(prd),
    .wr_i(pwx), .addr_i(padr), .wdata_i(pwd), .rdata_o(prdi));
  // free-running 100 MHz clock
  always #5 clk = ~clk;
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] x);
    cmp_count++;
    if (s !== x)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic results();
    if (bad_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [15:0] ba(input logic [4:0] b,
                                     input logic [6:0] o);
    return {2'b00, b, o, 2'b00};
  endfunction
  function automatic logic [15:0] la(input logic [11:0] i);
    return {2'b01, i, 2'b00};
  endfunction
  // one apb transfer; the request is held until pready is sampled high
  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d,
                     input logic s);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    pstrb  <= {3'h0, s};
    @(posedge clk);
    pen <= 1'b1;
    for (int i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    r = prdata[7:0];
    e = pslverr;
    chk("pready", {7'h0, pready}, 8'h01);
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] x, input logic xe);
    apb(1'b0, a, 8'h00, 1'b1);
    chk("read data", r, x);
    chk("read error", {7'h0, e}, {7'h0, xe});
  endtask
  // alu report; result is checked with done, flags one edge later
  task automatic alu(input csbl_op_t op, input logic [7:0] a, b,
                     input logic d, input logic [7:0] xr, xf);
    @(posedge clk);
    av  <= 1'b1;
    aop <= op;
    aa  <= a;
    ab  <= b;
    ads <= d;
    @(posedge clk);
    av  <= 1'b0;
    ads <= 1'b0;
    #1;
    chk("alu done", {7'h0, adone}, 8'h01);
    chk("alu result", ares, xr);
    @(posedge clk);
    #1;
    chk("flags", flags, xf);
  endtask
  // k: 0 watchdog clear, 1 sleep, 2 watchdog expiry
  task automatic pulse(input int k, input logic [7:0] xf);
    @(posedge clk);
    clrw <= (k == 0);
    slp  <= (k == 1);
    wexp <= (k == 2);
    @(posedge clk);
    clrw <= 1'b0;
    slp  <= 1'b0;
    wexp <= 1'b0;
    @(posedge clk);
    #1;
    chk("event flags", flags, xf);
  endtask
  task automatic do_rst(input logic p);
    @(posedge clk);
    rst_b <= 1'b0;
    por   <= p;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
  endtask
  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    do_rst(1'b1);
    chk("reset flags", flags, 8'h18);
    foreach (rows[i])
      alu(rows[i].op, rows[i].a, rows[i].b, 1'b0, rows[i].x, {5'h03, rows[i].f});
    do_rst(1'b0);
    chk("warm reset flags", flags, 8'h1c);
    do_rst(1'b1);
    rd(ba(5'd0, STATUS_OFS), 8'h18, 1'b0);
    apb(1'b1, ba(5'd2, STATUS_OFS), 8'hff, 1'b1);
    rd(ba(5'd31, STATUS_OFS), 8'h1f, 1'b0);
    alu(OP_ADD, 8'h0f, 8'h01, 1'b1, 8'h10, 8'h1a);
    alu(OP_CLR, 8'h00, 8'h00, 1'b1, 8'h00, 8'h1e);
    pulse(1, 8'h16);
    pulse(2, 8'h06);
    pulse(0, 8'h1e);
    apb(1'b1, ba(5'd1, 7'h20), 8'ha5, 1'b1);
    rd(la(12'd80), 8'ha5, 1'b0);
    apb(1'b1, la(12'd239), 8'h3c, 1'b1);
    rd(ba(5'd2, GEN_LAST), 8'h3c, 1'b0);
    apb(1'b1, ba(5'd1, 7'h20), 8'h00, 1'b0);
    rd(ba(5'd1, 7'h20), 8'ha5, 1'b0);
    apb(1'b1, ba(5'd0, 7'h75), 8'h77, 1'b1);
    rd(ba(5'd31, 7'h75), 8'h77, 1'b0);
    rd(ba(5'd3, GEN_FIRST), 8'h00, 1'b0);
    rd(16'h8000, 8'h00, 1'b1);
    rd(la(12'd240), 8'h00, 1'b1);
    apb(1'b1, ba(5'd1, PER_FIRST), 8'h5a, 1'b1);
    rd(ba(5'd1, PER_FIRST), 8'h5a, 1'b0);
    apb(1'b1, ba(5'd4, PER_LAST), 8'hc3, 1'b1);
    rd(ba(5'd4, PER_LAST), 8'hc3, 1'b0);
    results();
  end
  // the run needs well under a thousand cycles
  initial
  begin
    #50000;
    bad_count++;
    results();
  end
endmodule
`default_nettype wire

//--- csbl_alu_flags.sv
// csbl_alu_flags: result and zero/nibble-carry/carry of one core operation
// assumes: operands are stable while the core reports the operation

`timescale 1ns/1ps
`default_nettype none

module csbl_alu_flags
  import csbl_pkg::*;
(
  // operation
  input  wire csbl_op_t   op_i,
  input  wire logic [7:0] opa_i,
  input  wire logic [7:0] opb_i,
  input  wire logic       carry_i,
  // result and flags
  output logic [7:0]      result_o,
  output logic            zero_o,
  output logic            nibble_carry_o,
  output logic            carry_o,
  // which flags the operation updates
  output logic            upd_z_o,
  output logic            upd_dc_o,
  output logic            upd_c_o
);

  logic [8:0] sum9;
  logic [4:0] low5;
  logic [7:0] addend;
  logic       cin;

  // ---------------------------------------------------------------
  // adder: subtraction adds the two's complement, so carry is no-borrow
  // ---------------------------------------------------------------
  always_comb
  begin
    addend = (op_i == OP_SUB) ? ~opb_i : opb_i;
    cin    = (op_i == OP_SUB);
    sum9   = {1'b0, opa_i} + {1'b0, addend} + {8'h00, cin};
    low5   = {1'b0, opa_i[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
  end

  // ---------------------------------------------------------------
  // result and flag selection
  // ---------------------------------------------------------------
  always_comb
  begin
    result_o       = 8'h00;
    nibble_carry_o = low5[4];
    carry_o        = sum9[8];
    upd_z_o        = 1'b1;
    upd_dc_o       = 1'b0;
    upd_c_o        = 1'b0;
    unique case (op_i)
      OP_ADD, OP_SUB:
      begin
        result_o = sum9[7:0];
        upd_dc_o = 1'b1;
        upd_c_o  = 1'b1;
      end
      OP_AND: result_o = opa_i & opb_i;
      OP_IOR: result_o = opa_i | opb_i;
      OP_XOR: result_o = opa_i ^ opb_i;
      OP_CLR: result_o = 8'h00;
      OP_ROTR:
      begin
        result_o = {carry_i, opa_i[7:1]};
        carry_o  = opa_i[0];
        upd_z_o  = 1'b0;
        upd_c_o  = 1'b1;
      end
      OP_ROTL:
      begin
        result_o = {opa_i[6:0], carry_i};
        carry_o  = opa_i[7];
        upd_z_o  = 1'b0;
        upd_c_o  = 1'b1;
      end
    endcase
    zero_o = (result_o == 8'h00);
  end

endmodule

`default_nettype wire

//--- csbl_periph_model.sv
// csbl_periph_model: behavioural peripheral registers on the periph window
// assumes: read data is taken in the cycle the read strobe is high
`timescale 1ns/1ps
`default_nettype none
module csbl_periph_model
  import csbl_pkg::*;
(
  // clock
  input  wire logic              sys_clk_i,
  // strobes and address from the block
  input  wire logic              rd_i,
  input  wire logic              wr_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [7:0]        wdata_i,
  // read data back to the block
  output logic [7:0]             rdata_o
);
  // ------------------------------------------------------------
  // storage and read path
  // ------------------------------------------------------------
  logic [7:0] mem_r [0:(1<<ADDR_W)-1];
  logic [7:0] last_r = 8'h00;
  // writes land on the strobe; remember the last byte handed out
  always @(posedge sys_clk_i)
  begin
    if (wr_i)
      mem_r[addr_i] <= wdata_i;
    if (rd_i)
      last_r <= rdata_o;
  end
  // off the strobe the bus shows the inverse, so a late sample shows up
  assign rdata_o = rd_i ? mem_r[addr_i] : ~last_r;
endmodule
`default_nettype wire

//--- csbl_pkg.sv
// csbl_pkg: constants and types shared by the status and bank layout block
// assumes: byte-wide data memory reached over a 32-bit apb word per byte

package csbl_pkg;

  // ---------------------------------------------------------------
  // data memory address layout
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned BANK_W    = 5;
  localparam int unsigned OFS_W     = 7;
  localparam logic [6:0]  STATUS_OFS = 7'h03;
  localparam logic [6:0]  CORE_LAST = 7'h0b;
  localparam logic [6:0]  PER_FIRST = 7'h0c;
  localparam logic [6:0]  PER_LAST  = 7'h1f;
  localparam logic [6:0]  GEN_FIRST = 7'h20;
  localparam logic [6:0]  GEN_LAST  = 7'h6f;
  localparam logic [6:0]  COM_FIRST = 7'h70;
  localparam int unsigned GEN_BYTES = 80;
  localparam int unsigned COM_BYTES = 16;
  localparam int unsigned GEN_BANKS = 3;
  localparam int unsigned LIN_BYTES = GEN_BANKS * GEN_BYTES;
  localparam int unsigned RAM_BYTES = LIN_BYTES + COM_BYTES;
  localparam int unsigned RAM_AW    = 8;

  // ---------------------------------------------------------------
  // apb window selection, paddr[15:14]
  // ---------------------------------------------------------------
  localparam int unsigned PADDR_W   = 16;
  localparam logic [1:0]  WIN_BANKED = 2'h0;
  localparam logic [1:0]  WIN_LINEAR = 2'h1;

  // ---------------------------------------------------------------
  // flag register fields and reset values
  // ---------------------------------------------------------------
  localparam int unsigned BIT_TO  = 4;
  localparam int unsigned BIT_SLP = 3;
  localparam int unsigned BIT_Z   = 2;
  localparam int unsigned BIT_DC  = 1;
  localparam int unsigned BIT_C   = 0;
  localparam logic        RST_TO  = 1'b1;
  localparam logic        RST_SLP = 1'b1;
  localparam logic        RST_ARITH = 1'b0;

  // ---------------------------------------------------------------
  // alu operations reported by the core, and memory regions
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_CLR,
    OP_ROTR, OP_ROTL
  } csbl_op_t;

  typedef enum logic [1:0] {
    RG_CORE, RG_PER, RG_GEN, RG_COM
  } csbl_region_t;

endpackage

//--- csbl_ram.sv
// csbl_ram: byte storage for banked general ram and common ram
// assumes: one write port and one asynchronous read port, no reset of data

`timescale 1ns/1ps
`default_nettype none

module csbl_ram
  import csbl_pkg::*;
(
  // clock
  input  wire logic              sys_clk_i,
  // write port
  input  wire logic              we_i,
  input  wire logic [RAM_AW-1:0] waddr_i,
  input  wire logic [7:0]        wdata_i,
  // read port
  input  wire logic [RAM_AW-1:0] raddr_i,
  output logic [7:0]             rdata_o
);

  logic [7:0] mem [RAM_BYTES];

  // ---------------------------------------------------------------
  // storage; contents are undefined until software writes them
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (we_i)
      mem[waddr_i] <= wdata_i;
  end

  // read is combinational; the top registers it into prdata
  assign rdata_o = mem[raddr_i];

endmodule

`default_nettype wire

//--- csbl_top.sv
// csbl_top: core flag register and banked data memory layout behind apb
// assumes: the core reports each alu operation and reset event as pulses
//
// Contract
// - the flag register accepts apb writes only; alu writes to it are dropped, since every operation updates a flag
// - a flag-affecting instruction writing the register keeps its own z, dc, c
// - time-out and power-down flags are read-only to software
// - bits 7 to 5 of the flag register read as zero
// - time-out flag set by power-up, watchdog clear, sleep; cleared by time-out
// - power-down flag set by power-up or watchdog clear; cleared by sleep
// - zero flag is one exactly when a non-rotate operation result is zero
// - add/subtract set nibble carry from carry out of bit 3
// - add/subtract set carry from carry out of the top bit
// - subtraction adds the two's complement, carry meaning no borrow
// - rotates through carry load carry with the bit shifted out
// - reset sets time-out and power-down; arith flags clear on cold reset only
// - offsets 0x0c to 0x1f of each bank map 20 peripheral bytes
// - each bank holds up to 80 bytes of general ram
// - 16 bytes of common ram appear identically in every bank
// - general ram is also reachable in a linear non-banked space
// - addresses are 12 bits: 5 bank bits, 7 offset bits
// - core registers fill the first 12 offsets of every bank identically
// - unimplemented data memory reads as zero

`timescale 1ns/1ps
`default_nettype none

module csbl_top
  import csbl_pkg::*;
(
  // clock and reset
  input  wire logic               sys_clk_i,
  input  wire logic               rst_b_i,
  input  wire logic               cold_rst_i,
  // apb slave
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [PADDR_W-1:0] paddr_i,
  input  wire logic [31:0]        pwdata_i,
  input  wire logic [3:0]         pstrb_i,
  output logic [31:0]             prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  // alu operation report from the core
  input  wire logic               alu_valid_i,
  input  wire csbl_op_t           alu_op_i,
  input  wire logic [7:0]         alu_opa_i,
  input  wire logic [7:0]         alu_opb_i,
  input  wire logic               alu_dest_status_i,
  output logic [7:0]              alu_result_o,
  output logic                    alu_done_o,
  // reset and power events
  input  wire logic               watchdog_clear_instr_i,
  input  wire logic               sleep_instr_i,
  input  wire logic               watchdog_timer_expired_i,
  // flag register view
  output logic [7:0]              arith_reset_flags_o,
  // peripheral control register window
  output logic                    periph_rd_o,
  output logic                    periph_wr_o,
  output logic [ADDR_W-1:0]       periph_addr_o,
  output logic [7:0]              periph_wdata_o,
  input  wire logic [7:0]         periph_rdata_i
);

  // ---------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------
  function automatic csbl_region_t region_of(input logic [6:0] ofs);
    if (ofs <= CORE_LAST)
      return RG_CORE;
    else if (ofs <= PER_LAST)
      return RG_PER;
    else if (ofs <= GEN_LAST)
      return RG_GEN;
    else
      return RG_COM;
  endfunction

  // ram index for a banked address; ok is low for absent general ram
  function automatic logic [RAM_AW:0] ram_index(
    input logic [BANK_W-1:0] bank,
    input logic [6:0]        ofs
  );
    logic [11:0] idx;
    idx = 12'h000;
    if (region_of(ofs) == RG_COM)
    begin
      idx = 12'(LIN_BYTES) + {5'h00, ofs - COM_FIRST};
      return {1'b1, idx[RAM_AW-1:0]};
    end
    idx = 12'({7'h00, bank} * GEN_BYTES) + {5'h00, ofs - GEN_FIRST};
    return {(region_of(ofs) == RG_GEN) && (32'(bank) < GEN_BANKS),
            idx[RAM_AW-1:0]};
  endfunction

  // ---------------------------------------------------------------
  // apb decode of the current request
  // ---------------------------------------------------------------
  logic [1:0]         win;
  logic [ADDR_W-1:0]  maddr;
  logic [BANK_W-1:0]  bank;
  logic [6:0]         ofs;
  csbl_region_t       rgn;
  logic [RAM_AW:0]    bidx;
  logic               lin_ok;
  logic               ram_hit;
  logic [RAM_AW-1:0]  ram_idx;
  logic               is_status;
  logic               is_periph;
  logic               bad_addr;
  logic               setup_ph;
  logic               first_acc;
  logic               done_acc;
  logic               wr_done;
  logic [7:0]         wbyte;

  // byte address is four times the data memory address
  assign win      = paddr_i[15:14];
  assign maddr    = paddr_i[13:2];
  assign bank     = maddr[ADDR_W-1:OFS_W];
  assign ofs      = maddr[OFS_W-1:0];
  assign rgn      = region_of(ofs);
  assign bidx     = ram_index(bank, ofs);
  assign lin_ok   = (32'(maddr) < LIN_BYTES);
  assign bad_addr = (win != WIN_BANKED) && !((win == WIN_LINEAR) && lin_ok);
  assign is_status = (win == WIN_BANKED) && (ofs == STATUS_OFS);
  assign is_periph = (win == WIN_BANKED) && (rgn == RG_PER);
  assign ram_hit  = (win == WIN_BANKED) ? bidx[RAM_AW]
                                        : (win == WIN_LINEAR) && lin_ok;
  assign ram_idx  = (win == WIN_BANKED) ? bidx[RAM_AW-1:0]
                                        : maddr[RAM_AW-1:0];

  // one wait state: ready is raised in the second access cycle
  assign setup_ph  = psel_i && !penable_i;
  assign first_acc = psel_i && penable_i && !pready_o;
  assign done_acc  = psel_i && penable_i && pready_o;
  assign wr_done   = done_acc && pwrite_i && !bad_addr && pstrb_i[0];
  assign wbyte     = pwdata_i[7:0];

  // ---------------------------------------------------------------
  // alu flag computation
  // ---------------------------------------------------------------
  logic       z_r;
  logic       dc_r;
  logic       c_r;
  logic       to_n_r;
  logic       slp_n_r;
  logic [7:0] alu_res;
  logic       alu_z;
  logic       alu_dc;
  logic       alu_c;
  logic       upd_z;
  logic       upd_dc;
  logic       upd_c;

  csbl_alu_flags u_flags (
    .op_i           (alu_op_i),
    .opa_i          (alu_opa_i),
    .opb_i          (alu_opb_i),
    .carry_i        (c_r),
    .result_o       (alu_res),
    .zero_o         (alu_z),
    .nibble_carry_o (alu_dc),
    .carry_o        (alu_c),
    .upd_z_o        (upd_z),
    .upd_dc_o       (upd_dc),
    .upd_c_o        (upd_c)
  );

  // an alu destination write owns the cycle; a flag-setting op drops it whole
  logic       st_wr;
  logic [7:0] st_wdata;
  assign st_wr    = (alu_valid_i && alu_dest_status_i)
                    ? !(upd_z || upd_dc || upd_c)
                    : (wr_done && is_status);
  assign st_wdata = (alu_valid_i && alu_dest_status_i) ? alu_res : wbyte;

  // ---------------------------------------------------------------
  // arithmetic flags: the operation's own update beats the written value
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      if (cold_rst_i)
      begin
        z_r  <= RST_ARITH;
        dc_r <= RST_ARITH;
        c_r  <= RST_ARITH;
      end
    end
    else
    begin
      if (alu_valid_i && upd_z)
        z_r <= alu_z;
      else if (st_wr)
        z_r <= st_wdata[BIT_Z];
      if (alu_valid_i && upd_dc)
        dc_r <= alu_dc;
      else if (st_wr)
        dc_r <= st_wdata[BIT_DC];
      if (alu_valid_i && upd_c)
        c_r <= alu_c;
      else if (st_wr)
        c_r <= st_wdata[BIT_C];
    end
  end

  // ---------------------------------------------------------------
  // reset status flags: hardware only, software writes are dropped
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      to_n_r <= RST_TO;
      slp_n_r <= RST_SLP;
    end
    else
    begin
      // time-out has the last word; it reflects a real failure
      if (watchdog_timer_expired_i)
        to_n_r <= 1'b0;
      else if (watchdog_clear_instr_i || sleep_instr_i)
        to_n_r <= 1'b1;
      if (sleep_instr_i)
        slp_n_r <= 1'b0;
      else if (watchdog_clear_instr_i)
        slp_n_r <= 1'b1;
    end
  end

  logic [7:0] status_val;
  assign status_val = {3'b000, to_n_r, slp_n_r, z_r, dc_r, c_r};

  // ---------------------------------------------------------------
  // registered views of the flags and the alu result
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      arith_reset_flags_o <= 8'h00;
      alu_result_o        <= 8'h00;
      alu_done_o          <= 1'b0;
    end
    else
    begin
      arith_reset_flags_o <= status_val;
      alu_result_o        <= alu_valid_i ? alu_res : alu_result_o;
      alu_done_o          <= alu_valid_i;
    end
  end

  // ---------------------------------------------------------------
  // ram storage
  // ---------------------------------------------------------------
  logic [7:0] ram_rdata;

  csbl_ram u_ram (
    .sys_clk_i (sys_clk_i),
    .we_i      (wr_done && ram_hit),
    .waddr_i   (ram_idx),
    .wdata_i   (wbyte),
    .raddr_i   (ram_idx),
    .rdata_o   (ram_rdata)
  );

  // ---------------------------------------------------------------
  // peripheral window: read strobe in the first access cycle, rdata due in that same cycle
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      periph_rd_o    <= 1'b0;
      periph_wr_o    <= 1'b0;
      periph_addr_o  <= '0;
      periph_wdata_o <= 8'h00;
    end
    else
    begin
      periph_rd_o <= setup_ph && !pwrite_i && is_periph;
      periph_wr_o <= wr_done && is_periph;
      if (setup_ph && is_periph)
        periph_addr_o <= maddr;
      if (wr_done && is_periph)
        periph_wdata_o <= wbyte;
    end
  end

  // ---------------------------------------------------------------
  // apb answer: read data latched in the first access cycle
  // ---------------------------------------------------------------
  logic [7:0] rd_byte;

  always_comb
  begin
    rd_byte = 8'h00;
    if (is_status)
      rd_byte = status_val;
    else if (is_periph)
      rd_byte = periph_rdata_i;
    else if (ram_hit)
      rd_byte = ram_rdata;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end
    else
    begin
      pready_o  <= first_acc;
      pslverr_o <= first_acc && bad_addr;
      if (first_acc)
        prdata_o <= (pwrite_i || bad_addr) ? 32'h0000_0000
                                           : {24'h000000, rd_byte};
    end
  end

endmodule

`default_nettype wire

//--- csbl_top_asserts.sv
// csbl_top_asserts: timing and flag checks on the ports of csbl_top
// assumes: one clock, synchronous active-low reset, bound at the foot
`timescale 1ns/1ps
`default_nettype none
module csbl_top_asserts
  import csbl_pkg::*;
(
  // clock and reset
  input wire logic              sys_clk_i,
  input wire logic              rst_b_i,
  // apb and alu handshakes
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic              pready_o,
  input wire logic              alu_valid_i,
  input wire logic              alu_done_o,
  // reset and power events
  input wire logic              watchdog_clear_instr_i,
  input wire logic              sleep_instr_i,
  input wire logic              watchdog_timer_expired_i,
  // observed outputs
  input wire logic [7:0]        arith_reset_flags_o,
  input wire logic              periph_wr_o,
  input wire logic [ADDR_W-1:0] periph_addr_o
);
  // ------------------------------------------------------------
  // flag and handshake properties
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic ev;
  // outside reset, only an event pulse may move time-out or power-down, two edges on
  assign ev = watchdog_clear_instr_i | sleep_instr_i
            | watchdog_timer_expired_i;
  AST_UPPER_ZERO: assert property (
    arith_reset_flags_o[7:5] == 3'h0) else $error("flag bits 7:5 set");
  AST_RSTFLAG_HELD: assert property (
    $changed(arith_reset_flags_o[4:3]) |-> $past(ev, 2)
    || !$past(rst_b_i) || !$past(rst_b_i, 2)) else $error("reset flags moved");
  AST_EXPIRY_CLEARS: assert property (
    watchdog_timer_expired_i |-> ##2 !arith_reset_flags_o[BIT_TO])
    else $error("time-out flag not cleared");
  AST_TO_SET: assert property (
    (watchdog_clear_instr_i || sleep_instr_i) && !watchdog_timer_expired_i
    |-> ##2 arith_reset_flags_o[BIT_TO]) else $error("time-out not set");
  AST_SLEEP_CLEARS: assert property (
    sleep_instr_i |-> ##2 !arith_reset_flags_o[BIT_SLP])
    else $error("power-down flag not cleared");
  AST_WDCLR_SETS: assert property (
    watchdog_clear_instr_i && !sleep_instr_i
    |-> ##2 arith_reset_flags_o[BIT_SLP]) else $error("power-down not set");
  AST_DONE_NEXT: assert property (
    alu_valid_i |=> alu_done_o) else $error("alu done missing");
  AST_DONE_CAUSE: assert property (
    alu_done_o |-> $past(alu_valid_i)) else $error("alu done unprompted");
  AST_ONE_WAIT: assert property (
    psel_i && !penable_i |=> !pready_o ##1 pready_o)
    else $error("apb wait state count wrong");
  AST_PERIPH_WR: assert property (
    periph_wr_o |-> $past(pready_o && pwrite_i)
    && periph_addr_o[6:0] >= PER_FIRST && periph_addr_o[6:0] <= PER_LAST)
    else $error("peripheral write out of place");
endmodule
bind csbl_top csbl_top_asserts u_csbl_top_asserts (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .pready_o(pready_o),
  .alu_valid_i(alu_valid_i), .alu_done_o(alu_done_o),
  .watchdog_clear_instr_i(watchdog_clear_instr_i),
  .sleep_instr_i(sleep_instr_i),
  .watchdog_timer_expired_i(watchdog_timer_expired_i),
  .arith_reset_flags_o(arith_reset_flags_o), .periph_wr_o(periph_wr_o),
  .periph_addr_o(periph_addr_o)
);
`default_nettype wire
